/* dv/tb_tsl_serial_line.sv */
// testbench: terminal serial line interface against a host model
`timescale 1ns/1ps
module tb_tsl_serial_line;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] tx_rate_i = 4'h9;
  logic [3:0] rx_rate_i = 4'h8;
  logic split_speed_i = 1'b0;
  logic parity_enable_switch_i = 1'b1;
  logic [1:0] parity_sense_i = 2'h0;
  logic char_width_switch_i = 1'b1;
  logic async_mode_i = 1'b1;
  logic half_duplex_i = 1'b1;
  logic key_valid_i = 1'b0;
  logic [7:0] key_data_i = 8'h00;
  logic disp_ready_i = 1'b0;
  logic cts_i = 1'b0;
  logic carrier_i = 1'b0;
  logic [3:0] panel_state_i = 4'h0;
  logic keying_error_i = 1'b0;
  logic key_ready_o, disp_valid_o, disp_parity_err_o, rxd_i, txd_o, bell_o;
  logic [7:0] disp_data_o, indicators_o;
  logic [3:0] cap_bits = 4'hA;
  logic [9:0] cap;
  int cap_cnt, bit_cyc, bell_run, bell_len, n_mismatch, n_tests;
  logic [8:0] rxq[$];
  always #5 clk_sys_i = ~clk_sys_i;
  // a fast crystal step keeps 9600 baud frames near 1600 cycles per bit
  tsl_serial_line #(.FIFO_DEPTH(32), .XTAL_STEP(32'h0000_03FF)) DUT (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .tx_rate_i(tx_rate_i), .rx_rate_i(rx_rate_i),
    .split_speed_i(split_speed_i), .parity_enable_switch_i(parity_enable_switch_i),
    .parity_sense_i(parity_sense_i), .char_width_switch_i(char_width_switch_i),
    .async_mode_i(async_mode_i), .half_duplex_i(half_duplex_i), .key_valid_i(key_valid_i),
    .key_data_i(key_data_i), .key_ready_o(key_ready_o), .disp_valid_o(disp_valid_o),
    .disp_ready_i(disp_ready_i), .disp_data_o(disp_data_o),
    .disp_parity_err_o(disp_parity_err_o), .rxd_i(rxd_i), .txd_o(txd_o), .cts_i(cts_i),
    .carrier_i(carrier_i), .panel_state_i(panel_state_i), .keying_error_i(keying_error_i),
    .indicators_o(indicators_o), .bell_o(bell_o));
  tsl_host_model host (.clk_sys_i(clk_sys_i), .txd_i(txd_o), .rxd_o(rxd_i),
    .cap_bits_i(cap_bits), .cap_o(cap), .cap_cnt_o(cap_cnt), .bit_cyc_o(bit_cyc));
  // ****************************************
  // monitors and helpers
  // ****************************************
  // sampled mid-cycle so pops and alarm edges are settled
  always @(negedge clk_sys_i) begin
    if (disp_valid_o && disp_ready_i) rxq.push_back({disp_parity_err_o, disp_data_o});
    if (bell_o) bell_run++;
    else if (bell_run > 0) begin
      bell_len = bell_run;
      bell_run = 0;
    end
  end
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // hold the key until ready is seen, release after the taking edge
  task automatic key_send(input logic [7:0] d);
    int k;
    @(posedge clk_sys_i);
    key_valid_i <= 1'b1;
    key_data_i <= d;
    k = 0;
    @(negedge clk_sys_i);
    while (!key_ready_o && k < 100) begin
      @(negedge clk_sys_i);
      k++;
    end
    @(posedge clk_sys_i);
    key_valid_i <= 1'b0;
  endtask : key_send
  task automatic wait_cap(input int want);
    int k;
    k = 0;
    while (cap_cnt < want && k < 20000) begin
      @(posedge clk_sys_i);
      k++;
    end
    check(10'(cap_cnt), 10'(want));
  endtask : wait_cap
  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // ****************************************
  // tests
  // ****************************************
  // four frames of 16000 to 17600 cycles each, plus overlap and margin
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    // indicator sources walked through several patterns
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_sys_i);
      panel_state_i <= 4'(5 * p);
      {carrier_i, cts_i, keying_error_i} <= 3'(p + 3);
      repeat (3) @(posedge clk_sys_i);
      check(10'(indicators_o), 10'({carrier_i, half_duplex_i, cts_i, keying_error_i,
        panel_state_i}));
    end
    // 8 bits even parity, echo on, bell received while display stalls
    fork
      key_send(8'hA5);
      host.send_char(10'h107, 9);
    join
    wait_cap(1);
    check(cap, 10'h2A5);
    check(10'(bell_len), 10'h010);
    @(posedge clk_sys_i);
    disp_ready_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    check(10'(rxq.size()), 10'h002);
    check(10'(rxq[0]), 10'h0A5);
    check(10'(rxq[1]), 10'h007);
    // 7 bits odd parity, no echo, far end sends a bad parity bit
    parity_sense_i <= 2'h1;
    char_width_switch_i <= 1'b0;
    half_duplex_i <= 1'b0;
    cap_bits <= 4'h9;
    fork
      key_send(8'hC3);
      host.send_char(10'h041, 8);
    join
    wait_cap(2);
    check(cap & 10'h1FF, 10'h143);
    repeat (10) @(posedge clk_sys_i);
    check(10'(rxq.size()), 10'h003);
    check(10'(rxq[2]), 10'h141);
    // 8 bits mark parity
    parity_sense_i <= 2'h2;
    char_width_switch_i <= 1'b1;
    cap_bits <= 4'hA;
    key_send(8'h01);
    wait_cap(3);
    check(cap, 10'h301);
    // message link setting: 8 bits, no parity, both directions
    parity_enable_switch_i <= 1'b0;
    cap_bits <= 4'h9;
    fork
      key_send(8'h81);
      host.send_char(10'h0C1, 8);
    join
    wait_cap(4);
    check(cap & 10'h1FF, 10'h181);
    repeat (10) @(posedge clk_sys_i);
    check(10'(rxq.size()), 10'h004);
    check(10'(rxq[3]), 10'h0C1);
    print_verdict();
  end
endmodule : tb_tsl_serial_line

/* dv/tsl_host_model.sv */
// partner: behavioural host computer on the far end of the serial line
`timescale 1ns/1ps
module tsl_host_model (
  // clock and line
  input wire logic clk_sys_i,
  input wire logic txd_i,
  output logic rxd_o,
  // capture control and results
  input wire logic [3:0] cap_bits_i,
  output logic [9:0] cap_o,
  output int cap_cnt_o,
  output int bit_cyc_o
);
  initial begin
    rxd_o = 1'b1;
    cap_o = 10'h000;
    cap_cnt_o = 0;
    bit_cyc_o = 0;
  end
  // start bit width fixes the shared rate; needs a frame whose first data bit is one
  always begin
    int n;
    @(negedge txd_i);
    n = 0;
    while (!txd_i) begin
      @(posedge clk_sys_i);
      n++;
    end
    bit_cyc_o = n;
    repeat (n / 2) @(posedge clk_sys_i);
    // centre samples, lsb first, ending on the stop bit
    for (int i = 0; i < int'(cap_bits_i); i++) begin
      cap_o[i] = txd_i;
      repeat (n) @(posedge clk_sys_i);
    end
    cap_cnt_o++;
  end
  // one frame: start, bits lsb first, then the line marks through the stop bit
  task automatic send_char(input logic [9:0] bits, input int nb);
    while (bit_cyc_o == 0) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    rxd_o <= 1'b0;
    repeat (bit_cyc_o) @(posedge clk_sys_i);
    for (int i = 0; i < nb; i++) begin
      rxd_o <= bits[i];
      repeat (bit_cyc_o) @(posedge clk_sys_i);
    end
    rxd_o <= 1'b1;
    repeat (bit_cyc_o) @(posedge clk_sys_i);
  endtask : send_char
endmodule : tsl_host_model

/* dv/tsl_serial_line_chk.sv */
// checker: port-level assertions for the terminal serial line interface
`timescale 1ns/1ps
module tsl_serial_line_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // keyboard and line
  input wire logic key_valid_i,
  input wire logic key_ready_o,
  input wire logic txd_o,
  // display side
  input wire logic disp_valid_o,
  input wire logic disp_ready_i,
  input wire logic [7:0] disp_data_o,
  // switches and indicators
  input wire logic half_duplex_i,
  input wire logic cts_i,
  input wire logic carrier_i,
  input wire logic [3:0] panel_state_i,
  input wire logic keying_error_i,
  input wire logic [7:0] indicators_o,
  input wire logic bell_o
);
  logic [4:0] bell_cnt_reg;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // ****************************************
  // helpers
  // ****************************************
  // length of the current alarm pulse, cleared whenever the alarm is quiet
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !bell_o) begin
      bell_cnt_reg <= 5'h00;
    end else if (bell_cnt_reg != 5'h1F) begin
      bell_cnt_reg <= bell_cnt_reg + 5'h01;
    end
  end
  sequence s_take;
    key_valid_i && key_ready_o;
  endsequence
  sequence s_start_low;
    (!txd_o)[*8];
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  chk_reset_idle: assert property ($fell(reset_i) |-> txd_o && !bell_o && key_ready_o
    && !disp_valid_o && indicators_o == 8'h00) else $error("outputs not idle after reset");
  chk_start_bit: assert property (s_take |=> ##1 s_start_low)
    else $error("start bit missing or too short");
  chk_tx_busy: assert property (s_take |=> (!key_ready_o)[*8])
    else $error("keyboard taken while frame in flight");
  chk_idle_high: assert property (key_ready_o |-> txd_o)
    else $error("line not marking while transmitter idle");
  chk_indicator_map: assert property (!$past(reset_i) |-> indicators_o ==
    $past({carrier_i, half_duplex_i, cts_i, keying_error_i, panel_state_i}))
    else $error("indicators do not follow their sources");
  chk_bell_hold: assert property ($rose(bell_o) |-> bell_o[*8])
    else $error("alarm pulse cut short");
  chk_bell_len: assert property ($fell(bell_o) |-> bell_cnt_reg == 5'h10)
    else $error("alarm pulse length wrong");
  chk_disp_hold: assert property (disp_valid_o && !disp_ready_i |=>
    disp_valid_o && $stable(disp_data_o)) else $error("display entry lost while stalled");
endmodule : tsl_serial_line_chk

bind tsl_serial_line tsl_serial_line_chk u_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .key_valid_i(key_valid_i),
  .key_ready_o(key_ready_o), .txd_o(txd_o), .disp_valid_o(disp_valid_o),
  .disp_ready_i(disp_ready_i), .disp_data_o(disp_data_o), .half_duplex_i(half_duplex_i),
  .cts_i(cts_i), .carrier_i(carrier_i), .panel_state_i(panel_state_i),
  .keying_error_i(keying_error_i), .indicators_o(indicators_o), .bell_o(bell_o)
);

/* hw/tsl_fifo.sv */
// module: flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module tsl_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // fill side
  tsl_stream_if.snk in_if,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // honest full and empty from the occupancy count
  assign in_if.ready = (count_reg < (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push = in_if.valid && in_if.ready;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_reg];

  // storage
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_if.data;
    end
  end

  // pointers and count
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : tsl_fifo

/* hw/tsl_pkg.sv */
// package: constants and types for the terminal serial line interface
package tsl_pkg;
  // ****************************************
  // clocking
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned XTAL_HZ = 15_360_000;
  // crystal time base emulated by a fractional accumulator on clk_sys_i
  localparam logic [31:0] XTAL_INC = 32'h0000_009D;  // 15.36 MHz / 100 MHz * 2^10 = 157.3
  localparam int unsigned XTAL_ACC_W = 10;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hF;
  // ****************************************
  // rate selection codes
  // ****************************************
  localparam int unsigned RATE_W = 4;
  localparam logic [3:0] RATE_75 = 4'h0;
  localparam logic [3:0] RATE_110 = 4'h9;
  // divisors of the 15.36 MHz base down to 16x the bit rate
  localparam int unsigned DIV_W = 14;
  localparam logic [7:0] BELL_CODE = 8'h07;
  localparam int unsigned BELL_PULSE_CYCLES = 16;
  localparam logic [7:0] CHAR7_MASK = 8'h7F;
  // ****************************************
  // state machine
  // ****************************************
  typedef enum logic [2:0] {
    TSL_IDLE = 3'b000,
    TSL_START = 3'b001,
    TSL_DATA = 3'b011,
    TSL_PARITY = 3'b010,
    TSL_STOP = 3'b110
  } tsl_state_e;
  // parity sense: even, odd, mark
  typedef enum logic [1:0] {
    TSL_PAR_EVEN = 2'b00,
    TSL_PAR_ODD = 2'b01,
    TSL_PAR_MARK = 2'b10
  } tsl_par_e;
  // ****************************************
  // divisor table
  // ****************************************
  function automatic logic [13:0] tsl_divisor(input logic [3:0] rate);
    logic [13:0] d;
    d = 14'h3200;  // 75 baud: 15360000/(16*75) = 12800
    case (rate)
      4'h0: d = 14'h3200;  // 75
      4'h1: d = 14'h1900;  // 150
      4'h2: d = 14'h0C80;  // 300
      4'h3: d = 14'h0640;  // 600
      4'h4: d = 14'h0320;  // 1200
      4'h5: d = 14'h0215;  // 1800
      4'h6: d = 14'h0190;  // 2400
      4'h7: d = 14'h00C8;  // 4800
      4'h8: d = 14'h0064;  // 9600
      4'h9: d = 14'h2221;  // 110
      default: d = 14'h0064;
    endcase
    return d;
  endfunction : tsl_divisor
endpackage : tsl_pkg

/* hw/tsl_serial_line.sv */
// module: asynchronous serial line interface of a video terminal
`timescale 1ns/1ps
// Contract
// - line rate chosen from ten standard rates
// - normal setting: receive rate equals transmit rate
// - split speed: slow transmit, faster receive
// - frame: start, data lsb first, stop
// - nine, ten or eleven bit times per character
// - transmit parity even, odd or mark
// - switches: parity enable, sense, 7/8 bits
// - width switch affects asynchronous mode only
// - received bell code pulses alarm
// - eight-bit ascii characters on the line (seven bits when the width switch is off in asynchronous mode)
// - eight status indicators including cts, carrier
// - bit timing divided from 15.360 MHz base
module tsl_serial_line #(
  parameter int unsigned FIFO_DEPTH = 32,
  // crystal enable step per system clock, out of 2^10
  parameter logic [31:0] XTAL_STEP = tsl_pkg::XTAL_INC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // switches
  input wire logic [3:0] tx_rate_i,
  input wire logic [3:0] rx_rate_i,
  input wire logic split_speed_i,
  input wire logic parity_enable_switch_i,
  input wire logic [1:0] parity_sense_i,
  input wire logic char_width_switch_i,
  input wire logic async_mode_i,
  input wire logic half_duplex_i,
  // keyboard side
  input wire logic key_valid_i,
  input wire logic [7:0] key_data_i,
  output logic key_ready_o,
  // display side
  output logic disp_valid_o,
  input wire logic disp_ready_i,
  output logic [7:0] disp_data_o,
  output logic disp_parity_err_o,
  // line
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic cts_i,
  input wire logic carrier_i,
  // indicators and alarm
  input wire logic [3:0] panel_state_i,
  input wire logic keying_error_i,
  output logic [7:0] indicators_o,
  output logic bell_o
);
  // ****************************************
  // time base
  // ****************************************
  logic [tsl_pkg::XTAL_ACC_W:0] xtal_acc_reg;
  logic xtal_tick;
  logic [13:0] tx_div_reg;
  logic [13:0] rx_div_reg;
  logic tx_tick;
  logic rx_tick;
  logic [3:0] tx_sel;
  logic [3:0] rx_sel;
  logic [7:0] width_mask;
  logic [3:0] data_bits;

  // split speed lets tx and rx rates differ; otherwise one switch sets both
  assign tx_sel = split_speed_i ? tx_rate_i : rx_rate_i;
  assign rx_sel = rx_rate_i;
  // width switch only matters for asynchronous operation
  assign data_bits = (async_mode_i && !char_width_switch_i) ? 4'h7 : 4'h8;
  assign width_mask = (data_bits == 4'h7) ? tsl_pkg::CHAR7_MASK : 8'hFF;

  // fractional accumulator models the 15.36 MHz crystal enable
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      xtal_acc_reg <= '0;
    end else begin
      xtal_acc_reg <= {1'b0, xtal_acc_reg[tsl_pkg::XTAL_ACC_W-1:0]}
        + (tsl_pkg::XTAL_ACC_W+1)'(XTAL_STEP);
    end
  end
  assign xtal_tick = xtal_acc_reg[tsl_pkg::XTAL_ACC_W];

  // 16x dividers from the crystal enable
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_div_reg <= '0;
      rx_div_reg <= '0;
    end else begin
      if (xtal_tick) begin
        tx_div_reg <= (tx_div_reg >= tsl_pkg::tsl_divisor(tx_sel) - 1'b1) ? '0 : tx_div_reg + 1'b1;
        rx_div_reg <= (rx_div_reg >= tsl_pkg::tsl_divisor(rx_sel) - 1'b1) ? '0 : rx_div_reg + 1'b1;
      end
      // restart the bit clock at the take so the start bit is a full bit time
      if (key_valid_i && key_ready_o) begin
        tx_div_reg <= 14'h0001;
      end
    end
  end
  assign tx_tick = xtal_tick && (tx_div_reg == '0);
  assign rx_tick = xtal_tick && (rx_div_reg == '0);

  // ****************************************
  // transmitter
  // ****************************************
  tsl_pkg::tsl_state_e tx_state_reg;
  logic [3:0] tx_os_reg;
  logic [3:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic tx_par_reg;
  logic tx_bit_end;

  assign tx_bit_end = tx_tick && (tx_os_reg == tsl_pkg::LAST_TICK);
  assign key_ready_o = (tx_state_reg == tsl_pkg::TSL_IDLE);

  // frame: start, data lsb first, optional parity, stop
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_state_reg <= tsl_pkg::TSL_IDLE;
      tx_os_reg <= '0;
      tx_bit_reg <= '0;
      tx_shift_reg <= '0;
      tx_par_reg <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      if (tx_tick) begin
        tx_os_reg <= tx_os_reg + 1'b1;
      end
      case (tx_state_reg)
        tsl_pkg::TSL_IDLE: begin
          txd_o <= 1'b1;
          if (key_valid_i) begin
            tx_shift_reg <= key_data_i & width_mask;
            tx_par_reg <= ^(key_data_i & width_mask);
            tx_os_reg <= '0;
            tx_state_reg <= tsl_pkg::TSL_START;
          end
        end
        tsl_pkg::TSL_START: begin
          txd_o <= 1'b0;
          if (tx_bit_end) begin
            tx_bit_reg <= '0;
            tx_state_reg <= tsl_pkg::TSL_DATA;
          end
        end
        tsl_pkg::TSL_DATA: begin
          txd_o <= tx_shift_reg[0];
          if (tx_bit_end) begin
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 1'b1;
            if (tx_bit_reg == data_bits - 1'b1) begin
              tx_state_reg <= parity_enable_switch_i ? tsl_pkg::TSL_PARITY : tsl_pkg::TSL_STOP;
            end
          end
        end
        tsl_pkg::TSL_PARITY: begin
          case (parity_sense_i)
            tsl_pkg::TSL_PAR_EVEN: txd_o <= tx_par_reg;
            tsl_pkg::TSL_PAR_ODD: txd_o <= ~tx_par_reg;
            default: txd_o <= 1'b1;
          endcase
          if (tx_bit_end) begin
            tx_state_reg <= tsl_pkg::TSL_STOP;
          end
        end
        tsl_pkg::TSL_STOP: begin
          txd_o <= 1'b1;
          if (tx_bit_end) begin
            tx_state_reg <= tsl_pkg::TSL_IDLE;
          end
        end
        default: tx_state_reg <= tsl_pkg::TSL_IDLE;
      endcase
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  tsl_pkg::tsl_state_e rx_state_reg;
  logic [3:0] rx_os_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic rx_prev_reg;
  logic rx_perr_reg;
  logic rx_done;
  logic rx_mid;
  logic rx_exp_par;
  tsl_stream_if #(.WIDTH(9)) rx_if ();

  assign rx_mid = rx_tick && (rx_os_reg == tsl_pkg::MID_SAMPLE);
  assign rx_done = (rx_state_reg == tsl_pkg::TSL_STOP) && rx_mid;

  // expected parity of the received data under the current switches
  always_comb begin
    case (parity_sense_i)
      tsl_pkg::TSL_PAR_EVEN: rx_exp_par = ^rx_shift_reg;
      tsl_pkg::TSL_PAR_ODD: rx_exp_par = ~^rx_shift_reg;
      default: rx_exp_par = 1'b1;
    endcase
  end

  // start edge, then centre sampling of each bit; a far-end parity mismatch sets the error flag
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_state_reg <= tsl_pkg::TSL_IDLE;
      rx_os_reg <= '0;
      rx_bit_reg <= '0;
      rx_shift_reg <= '0;
      rx_prev_reg <= 1'b1;
      rx_perr_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rxd_i;
      if (rx_tick) begin
        rx_os_reg <= rx_os_reg + 1'b1;
      end
      case (rx_state_reg)
        tsl_pkg::TSL_IDLE: begin
          if (rx_prev_reg && !rxd_i) begin
            rx_os_reg <= '0;
            rx_state_reg <= tsl_pkg::TSL_START;
          end
        end
        tsl_pkg::TSL_START: begin
          if (rx_mid) begin
            // a short glitch is not a start bit
            rx_state_reg <= rxd_i ? tsl_pkg::TSL_IDLE : tsl_pkg::TSL_DATA;
            rx_bit_reg <= '0;
            rx_shift_reg <= '0;
            rx_perr_reg <= 1'b0;
          end
        end
        tsl_pkg::TSL_DATA: begin
          if (rx_mid) begin
            rx_shift_reg[rx_bit_reg[2:0]] <= rxd_i;
            rx_bit_reg <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == data_bits - 1'b1) begin
              rx_state_reg <= parity_enable_switch_i ? tsl_pkg::TSL_PARITY : tsl_pkg::TSL_STOP;
            end
          end
        end
        tsl_pkg::TSL_PARITY: begin
          if (rx_mid) begin
            rx_perr_reg <= (rxd_i != rx_exp_par);
            rx_state_reg <= tsl_pkg::TSL_STOP;
          end
        end
        tsl_pkg::TSL_STOP: begin
          if (rx_mid) begin
            rx_state_reg <= tsl_pkg::TSL_IDLE;
          end
        end
        default: rx_state_reg <= tsl_pkg::TSL_IDLE;
      endcase
    end
  end

  // ****************************************
  // display path through the fifo
  // ****************************************
  logic echo_pending_reg;
  logic [7:0] echo_data_reg;
  logic [8:0] fifo_out;
  logic fifo_valid;

  // half duplex copies keyed characters to the display as well
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      echo_pending_reg <= 1'b0;
      echo_data_reg <= '0;
    end else if (key_valid_i && key_ready_o && half_duplex_i) begin
      echo_pending_reg <= 1'b1;
      echo_data_reg <= key_data_i & width_mask;
    end else if (!rx_done && rx_if.ready) begin
      echo_pending_reg <= 1'b0;
    end
  end

  // received characters win the fifo port; an echo waits one slot
  // limitation: a character arriving on a full fifo is dropped
  assign rx_if.valid = rx_done || echo_pending_reg;
  assign rx_if.data = rx_done ? {rx_perr_reg, rx_shift_reg} : {1'b0, echo_data_reg};

  tsl_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_if(rx_if),
    .out_valid_o(fifo_valid),
    .out_ready_i(disp_ready_i),
    .out_data_o(fifo_out)
  );
  assign disp_valid_o = fifo_valid;
  assign disp_data_o = fifo_out[7:0];
  assign disp_parity_err_o = fifo_out[8];

  // ****************************************
  // bell and indicators
  // ****************************************
  logic [4:0] bell_cnt_reg;

  // stretch the alarm so a slow sounder sees it
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bell_cnt_reg <= '0;
    end else if (rx_done && ((rx_shift_reg & tsl_pkg::CHAR7_MASK) == tsl_pkg::BELL_CODE)) begin
      bell_cnt_reg <= 5'(tsl_pkg::BELL_PULSE_CYCLES);
    end else if (bell_cnt_reg != '0) begin
      bell_cnt_reg <= bell_cnt_reg - 1'b1;
    end
  end
  assign bell_o = (bell_cnt_reg != '0);

  // ready, insert, locked, display area from the panel; rest from carrier, duplex switch, cts and keying error
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      indicators_o <= '0;
    end else begin
      indicators_o <= {carrier_i, half_duplex_i, cts_i, keying_error_i, panel_state_i};
    end
  end
endmodule : tsl_serial_line

/* hw/tsl_stream_if.sv */
// interface: valid/ready character stream between the serial core and its fifo
`timescale 1ns/1ps
interface tsl_stream_if #(parameter int unsigned WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : tsl_stream_if
